// *** design/bel_params.svh ***
// constants for the bus error status logger
`ifndef BEL_PARAMS_SVH
`define BEL_PARAMS_SVH
`define BEL_ADDR_W 8
`define BEL_DATA_W 32
`define BEL_FLAG_W 24
`define BEL_OFS_STATUS 8'h40
`define BEL_OFS_CONFIG 8'h80
`define BEL_NUM_SYN 4
`define BEL_NUM_REQ 10
`define BEL_ADR_HI 39
`define BEL_ADR_LO 3
`define BEL_BANK_W 4
`define BEL_CMD_W 3
// status bit positions
`define BEL_B_DS_HI 23
`define BEL_B_DS_LO 20
`define BEL_B_SECOND_CORR_WRITE_ERR 19
`define BEL_B_CORR_READ_ERR 18
`define BEL_B_CWDE 17
`define BEL_B_UDE 16
`define BEL_B_ATDE 10
`define BEL_B_REQUEST_DROP_ERR 9
`define BEL_B_FATAL_NO_ACK_ERR 8
`define BEL_B_MAP_TRANSLATE_ERR 7
`define BEL_B_ACK_XMIT_CHECK_ERR 6
`define BEL_B_REQ_XMIT_CHECK_ERR 5
`define BEL_B_NAE 4
`define BEL_B_LKTO 3
`define BEL_B_BAE 2
`define BEL_B_APE 1
`define BEL_B_ADDR_XMIT_CHECK_ERR 0
// configuration bit positions
`define BEL_C_FREEZE 31
`define BEL_C_LOCK_TIMEOUT_DISABLE 2
`define BEL_C_CORR_READ_IRQ_DISABLE 1
`define BEL_C_CORR_WRITE_IRQ_DISABLE 0
// reset values and masks
`define BEL_STATUS_RST 24'h000000
`define BEL_LOCK_MASK 24'h0F07FF
`define BEL_FATAL_MASK 24'h000367
`define BEL_IMPL_CPU 24'hFF07F7
`define BEL_IMPL_MEM 24'hFF004E
`define BEL_IMPL_IO 24'hFF07F7
`endif

// *** design/bel_pkg.sv ***
// types shared by the bus error status logger
`include "bel_params.svh"
package bel_pkg;
   typedef enum logic [1:0] {NODE_CPU, NODE_MEM, NODE_IO} bel_node_kind_t;
   // per syndrome register ecc classification
   typedef struct packed {
      logic [`BEL_NUM_SYN-1:0] corr_read_ecc_flag;
      logic [`BEL_NUM_SYN-1:0] corr_write_ecc_flag;
      logic [`BEL_NUM_SYN-1:0] uecc;
   } bel_ecc_evt_t;
   // address cycle fields as driven or sensed
   typedef struct packed {
      logic [`BEL_ADR_HI:`BEL_ADR_LO] adr;
      logic adr_par;
      logic [`BEL_BANK_W-1:0] bank;
      logic [`BEL_CMD_W-1:0] cmd;
      logic cmd_par;
   } bel_addr_bus_t;
   // single-cycle protocol events from the node logic
   typedef struct packed {
      logic req_not_dropped;
      logic mem_no_ack;
      logic csr_no_ack;
      logic csr_is_write;
      logic csr_to_mailbox;
      logic map_miss;
      logic bank_busy_hit;
      logic csr_overlap;
      logic lock_timeout;
   } bel_bus_evt_t;
endpackage

// *** design/bel_logger.sv ***
// bus error status register with error detection and bus line signalling
//
// Function
// - pointer bit n set when syndrome register n holds current data error status.
// - pointer bits rewritten when a more significant data error arrives.
// - second correctable write flag sets on repeat correctable write error.
// - correctable read flag sets; data error line unless read disable set.
// - correctable write flag sets; data error line unless write disable set.
// - io node posts level 17 interrupt after correctable data error line.
// - uncorrectable flag sets, drives data error line; io posts interrupt.
// - transmitter flag sets on missing acknowledge while this node drove address.
// - arbitration winner not dropping request sets flag and drives fault.
// - missing acknowledge on memory command sets fatal flag and fault.
// - mapping miss sets flag, command forced to no-op, io interrupt.
// - acknowledge transmit check sets flag, fault; io commander sets no-ack.
// - request line transmit check sets flag and drives fault.
// - missing acknowledge on register command sets flag; io interrupt.
// - cpu register write miss sets nonexistent write unless to mailbox; read miss fill error.
// - memory lock timeout sets flag, drives bank available, unless disabled.
// - busy bank or overlapping register command sets flag and fault.
// - even address parity sets parity flag, fault and transmitter flag.
// - address transmit check sets flag, fault and transmitter flag.
// - freeze enabled: first non-pointer flag freezes register until cleared.
// - correctable read disable stops data error line on read errors.
`timescale 1ns/100ps
`include "bel_params.svh"
module bel_logger #(
   parameter bel_pkg::bel_node_kind_t NODE_KIND = bel_pkg::NODE_CPU
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [`BEL_ADDR_W-1:0] reg_addr,
   input wire logic [`BEL_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [`BEL_DATA_W-1:0] reg_rdata,
   input wire logic io_irq_enable,
   input wire bel_pkg::bel_ecc_evt_t ecc_evt,
   input wire bel_pkg::bel_bus_evt_t bus_evt,
   input wire logic addr_check_en,
   input wire logic addr_drive_en,
   input wire bel_pkg::bel_addr_bus_t addr_driven,
   input wire bel_pkg::bel_addr_bus_t addr_sensed,
   input wire logic [`BEL_NUM_REQ-1:0] arb_request_drive,
   input wire logic [`BEL_NUM_REQ-1:0] arb_request_sensed,
   input wire logic ack_drive,
   input wire logic ack_sensed,
   input wire logic node_was_addr_xmitter,
   input wire logic io_commander,
   output logic system_fault_line,
   output logic data_error_line,
   output logic bank_available_assert,
   output logic irq17_post,
   output logic cmd_noop,
   output logic csr_nxm_wr,
   output logic fill_error
);

   // even parity over a group means an error (zero padding is harmless)
   function automatic logic bel_even_par(input logic [63:0] v);
      bel_even_par = ~(^v);
   endfunction

   // flags that a node kind implements
   function automatic logic [`BEL_FLAG_W-1:0] bel_impl(input bel_pkg::bel_node_kind_t k);
      if (k == bel_pkg::NODE_MEM)
         bel_impl = `BEL_IMPL_MEM;
      else if (k == bel_pkg::NODE_IO)
         bel_impl = `BEL_IMPL_IO;
      else
         bel_impl = `BEL_IMPL_CPU;
   endfunction

   localparam logic [`BEL_FLAG_W-1:0] IMPL = bel_impl(NODE_KIND);
   localparam logic IS_IO = (NODE_KIND == bel_pkg::NODE_IO);
   localparam logic IS_CPU = (NODE_KIND == bel_pkg::NODE_CPU);
   localparam logic IS_MEM = (NODE_KIND == bel_pkg::NODE_MEM);

   logic [`BEL_FLAG_W-1:0] status;
   logic [`BEL_FLAG_W-1:0] next_status;
   logic cfg_freeze;
   logic cfg_lock_timeout_disable;
   logic cfg_corr_read_irq_disable;
   logic cfg_corr_write_irq_disable;
   logic corr_irq_pend;

   // register decode
   wire sel_status = (reg_addr == `BEL_OFS_STATUS);
   wire sel_config = (reg_addr == `BEL_OFS_CONFIG);
   wire wr_status = reg_wr && sel_status;
   wire wr_config = reg_wr && sel_config;

   // address parity groups; io nodes leave the low address pair out
   wire [1:0] adr_lo_pair = IS_IO ? 2'h0 : addr_sensed.adr[4:3];
   wire par_grp_a = bel_even_par({37'h0, addr_sensed.adr[30:5], addr_sensed.adr_par});
   wire par_grp_b = bel_even_par({45'h0, addr_sensed.adr[39:31], adr_lo_pair,
                                  addr_sensed.bank, addr_sensed.cmd, addr_sensed.cmd_par});
   wire ape_evt = addr_check_en && (par_grp_a || par_grp_b);

   // transmit checks compare what this node drove against what the bus shows
   wire [`BEL_ADR_HI:`BEL_ADR_LO] adr_cmp_mask = IS_IO ? 37'h1FFFFFFFFC : 37'h1FFFFFFFFF;
   wire adr_diff = |((addr_driven.adr ^ addr_sensed.adr) & adr_cmp_mask);
   wire ctl_diff = (addr_driven.adr_par != addr_sensed.adr_par) ||
                   (addr_driven.bank != addr_sensed.bank) ||
                   (addr_driven.cmd != addr_sensed.cmd) ||
                   (addr_driven.cmd_par != addr_sensed.cmd_par);
   wire addr_xmit_check_err_evt = addr_drive_en && (adr_diff || ctl_diff);
   // request transmit check over all ten request lines
   wire req_xmit_check_err_evt = |(arb_request_drive & ~arb_request_sensed);
   wire ack_xmit_check_err_evt = ack_drive && !ack_sensed;

   // ecc classification
   wire any_corr_read_ecc_flag = |ecc_evt.corr_read_ecc_flag;
   wire any_corr_write_ecc_flag = |ecc_evt.corr_write_ecc_flag;
   wire any_uecc = |ecc_evt.uecc;
   wire any_data_evt = any_corr_read_ecc_flag || any_corr_write_ecc_flag || any_uecc;
   wire [1:0] new_sig = any_uecc ? 2'h2 : (any_data_evt ? 2'h1 : 2'h0);
   wire [1:0] cur_sig = status[`BEL_B_UDE] ? 2'h2 :
                        ((status[`BEL_B_CORR_READ_ERR] || status[`BEL_B_CWDE]) ? 2'h1 : 2'h0);
   wire [`BEL_NUM_SYN-1:0] new_ds = any_uecc ? ecc_evt.uecc : (ecc_evt.corr_read_ecc_flag | ecc_evt.corr_write_ecc_flag);
   // pointer bits mark the registers of the current error
   // rewrite only when undefined or outranked
   wire ds_load = (new_sig != 2'h0) && (new_sig > cur_sig);

   // timeout honoured only when not disabled
   wire lkto_evt = bus_evt.lock_timeout && !cfg_lock_timeout_disable;
   // transmitter involvement; io nodes also count bank violations
   wire bae_evt = bus_evt.bank_busy_hit || bus_evt.csr_overlap;
   wire nae_evt = bus_evt.csr_no_ack || (IS_IO && io_commander && ack_xmit_check_err_evt);
   wire atde_evt = (node_was_addr_xmitter && (bus_evt.mem_no_ack || nae_evt)) ||
                   ape_evt || addr_xmit_check_err_evt || (IS_IO && bae_evt);

   // per-flag set events before the implementation mask
   logic [`BEL_FLAG_W-1:0] raw_set;
   always_comb
   begin
      raw_set = `BEL_STATUS_RST;
      raw_set[`BEL_B_SECOND_CORR_WRITE_ERR] = any_corr_write_ecc_flag && status[`BEL_B_CWDE];
      raw_set[`BEL_B_CORR_READ_ERR] = any_corr_read_ecc_flag;
      raw_set[`BEL_B_CWDE] = any_corr_write_ecc_flag;
      raw_set[`BEL_B_UDE] = any_uecc;
      raw_set[`BEL_B_ATDE] = atde_evt;
      raw_set[`BEL_B_REQUEST_DROP_ERR] = bus_evt.req_not_dropped;
      raw_set[`BEL_B_FATAL_NO_ACK_ERR] = bus_evt.mem_no_ack;
      raw_set[`BEL_B_MAP_TRANSLATE_ERR] = bus_evt.map_miss;
      raw_set[`BEL_B_ACK_XMIT_CHECK_ERR] = ack_xmit_check_err_evt;
      raw_set[`BEL_B_REQ_XMIT_CHECK_ERR] = req_xmit_check_err_evt;
      raw_set[`BEL_B_NAE] = nae_evt;
      raw_set[`BEL_B_LKTO] = lkto_evt;
      raw_set[`BEL_B_BAE] = bae_evt;
      raw_set[`BEL_B_APE] = ape_evt;
      raw_set[`BEL_B_ADDR_XMIT_CHECK_ERR] = addr_xmit_check_err_evt;
   end

   wire [`BEL_FLAG_W-1:0] set_vec = raw_set & IMPL;
   // frozen once any locking flag stands while freeze is enabled
   wire frozen = cfg_freeze && |(status & `BEL_LOCK_MASK);
   // write one clears every flag except the pointer bits, zeros leave flags alone
   wire [`BEL_FLAG_W-1:0] clr_vec = wr_status ? (reg_wdata[`BEL_FLAG_W-1:0] & `BEL_LOCK_MASK)
                                              : `BEL_STATUS_RST;

   // next flag value: unless frozen, a set in the clearing cycle wins over the clear
   always_comb
   begin
      next_status = status & ~clr_vec;
      if (!frozen)
      begin
         next_status = next_status | (set_vec & `BEL_LOCK_MASK);
         if (ds_load)
            next_status[`BEL_B_DS_HI:`BEL_B_DS_LO] = new_ds;
      end
   end

   // line drive conditions
   wire fatal_evt = |(set_vec & `BEL_FATAL_MASK);
   wire crd_line = set_vec[`BEL_B_CORR_READ_ERR] && !cfg_corr_read_irq_disable;
   wire cwd_line = set_vec[`BEL_B_CWDE] && !cfg_corr_write_irq_disable;
   wire de_evt = crd_line || cwd_line || set_vec[`BEL_B_UDE];
   // io interrupt for unacknowledged, mapping and uncorrectable errors
   wire irq_now = IS_IO && io_irq_enable &&
                  (set_vec[`BEL_B_UDE] || set_vec[`BEL_B_MAP_TRANSLATE_ERR] || set_vec[`BEL_B_NAE]);

   // flags and configuration on the bus clock, cleared by reset
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         status <= `BEL_STATUS_RST;
         cfg_freeze <= 1'b0;
         cfg_lock_timeout_disable <= 1'b0;
         cfg_corr_read_irq_disable <= 1'b0;
         cfg_corr_write_irq_disable <= 1'b0;
      end
      else
      begin
         status <= next_status;
         if (wr_config)
         begin
            cfg_freeze <= reg_wdata[`BEL_C_FREEZE];
            cfg_lock_timeout_disable <= IS_MEM && reg_wdata[`BEL_C_LOCK_TIMEOUT_DISABLE];
            cfg_corr_read_irq_disable <= reg_wdata[`BEL_C_CORR_READ_IRQ_DISABLE];
            cfg_corr_write_irq_disable <= reg_wdata[`BEL_C_CORR_WRITE_IRQ_DISABLE];
         end
      end
   end

   // read data one cycle after the strobe; unmapped reads give zero
   wire [`BEL_DATA_W-1:0] status_word = {8'h00, status};
   wire [`BEL_DATA_W-1:0] config_word = {cfg_freeze, 28'h0000000, cfg_lock_timeout_disable, cfg_corr_read_irq_disable, cfg_corr_write_irq_disable};
   wire [`BEL_DATA_W-1:0] rd_mux = sel_status ? status_word :
                                   (sel_config ? config_word : 32'h00000000);
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         reg_rdata <= 32'h00000000;
      else if (reg_rd)
         reg_rdata <= rd_mux;
      else
         reg_rdata <= 32'h00000000;
   end

   // bus line pulses, one cycle after the detecting event
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         system_fault_line <= 1'b0;
         data_error_line <= 1'b0;
         bank_available_assert <= 1'b0;
         cmd_noop <= 1'b0;
         csr_nxm_wr <= 1'b0;
         fill_error <= 1'b0;
         corr_irq_pend <= 1'b0;
      end
      else
      begin
         // fatal errors drive the fault line
         system_fault_line <= fatal_evt;
         // data error line for enabled correctable and all hard data errors
         data_error_line <= de_evt;
         // bank available driven with the timeout flag
         bank_available_assert <= set_vec[`BEL_B_LKTO];
         cmd_noop <= set_vec[`BEL_B_MAP_TRANSLATE_ERR];
         csr_nxm_wr <= IS_CPU && bus_evt.csr_no_ack && bus_evt.csr_is_write &&
                       !bus_evt.csr_to_mailbox;
         fill_error <= IS_CPU && bus_evt.csr_no_ack && !bus_evt.csr_is_write;
         // remember a correctable line drive for the next cycle's interrupt
         corr_irq_pend <= IS_IO && io_irq_enable && (crd_line || cwd_line);
      end
   end

   // interrupt: direct causes now, correctable causes after the line
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         irq17_post <= 1'b0;
      else
         irq17_post <= irq_now || corr_irq_pend;
   end

   // checks
   fault_on_fatal_a: assert property (@(posedge ref_clk) disable iff (rst)
      (bus_evt.req_not_dropped && IMPL[`BEL_B_REQUEST_DROP_ERR]) |=> system_fault_line)
      else $error("fault line missed after request not dropped");
   fault_on_noack_a: assert property (@(posedge ref_clk) disable iff (rst)
      (bus_evt.mem_no_ack && IMPL[`BEL_B_FATAL_NO_ACK_ERR]) |=> system_fault_line)
      else $error("fault line missed after memory no-ack");
   crd_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
      (any_corr_read_ecc_flag && !any_corr_write_ecc_flag && !any_uecc && cfg_corr_read_irq_disable) |=> !data_error_line)
      else $error("data error line driven while read disable set");
   crd_line_a: assert property (@(posedge ref_clk) disable iff (rst)
      (any_corr_read_ecc_flag && !cfg_corr_read_irq_disable) |=> data_error_line)
      else $error("data error line missing for correctable read");
   cwd_line_a: assert property (@(posedge ref_clk) disable iff (rst)
      (any_corr_write_ecc_flag && !cfg_corr_write_irq_disable) |=> data_error_line)
      else $error("data error line missing for correctable write");
   ude_line_a: assert property (@(posedge ref_clk) disable iff (rst)
      any_uecc |=> (data_error_line && ($past(frozen) || status[`BEL_B_UDE])))
      else $error("uncorrectable error not logged or signalled");
   second_corr_write_err_set_a: assert property (@(posedge ref_clk) disable iff (rst)
      (any_corr_write_ecc_flag && status[`BEL_B_CWDE] && !frozen && IMPL[`BEL_B_SECOND_CORR_WRITE_ERR])
      |=> status[`BEL_B_SECOND_CORR_WRITE_ERR])
      else $error("second correctable write flag not set");
   freeze_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
      (frozen && !wr_status && !wr_config) |=> $stable(status))
      else $error("status changed while frozen");
   w1c_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
      (wr_status && !reg_wdata[`BEL_B_ACK_XMIT_CHECK_ERR] && status[`BEL_B_ACK_XMIT_CHECK_ERR])
      |=> status[`BEL_B_ACK_XMIT_CHECK_ERR])
      else $error("flag lost on write of zero");
   rsvd_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
      status[15:11] == 5'h00)
      else $error("reserved status bits not zero");
   ape_atde_a: assert property (@(posedge ref_clk) disable iff (rst)
      (ape_evt && !frozen && IMPL[`BEL_B_ATDE])
      |=> (status[`BEL_B_APE] && status[`BEL_B_ATDE] && system_fault_line))
      else $error("parity error did not log both flags");
   lkto_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
      (bus_evt.lock_timeout && cfg_lock_timeout_disable) |=> !bank_available_assert)
      else $error("lock timeout signalled while disabled");
   io_corr_irq_a: assert property (@(posedge ref_clk) disable iff (rst)
      (IS_IO && io_irq_enable && any_corr_read_ecc_flag && !cfg_corr_read_irq_disable)
      |=> data_error_line ##1 irq17_post)
      else $error("interrupt did not follow correctable data error");
   reset_clear_a: assert property (@(posedge ref_clk)
      rst |=> (status == `BEL_STATUS_RST))
      else $error("reset did not clear flags");

endmodule

// *** test/bel_bus_model.sv ***
// far-side bus nodes: wired request and ack lines, address cycles with parity
`timescale 1ns/100ps
`include "bel_params.svh"
module bel_bus_model (
   input wire logic ref_clk,
   input wire logic [`BEL_NUM_REQ-1:0] req_drive,
   input wire logic [`BEL_NUM_REQ-1:0] req_pull,
   output logic [`BEL_NUM_REQ-1:0] req_sensed,
   input wire logic ack_drive,
   input wire logic ack_pull,
   output logic ack_sensed,
   input wire bel_pkg::bel_addr_bus_t addr_src,
   input wire logic bus_cyc,
   input wire logic par_flip,
   input wire logic adr_flip,
   output bel_pkg::bel_addr_bus_t addr_good,
   output bel_pkg::bel_addr_bus_t addr_sensed
);
   logic idle_tog = 1'b0;
   bel_pkg::bel_addr_bus_t bad;
   // idle address bus flips every cycle so a stale value is never seen
   always @(posedge ref_clk)
   begin
      idle_tog <= ~idle_tog;
   end
   assign req_sensed = req_drive & ~req_pull;
   assign ack_sensed = ack_drive & ~ack_pull;
   always_comb
   begin
      addr_good = addr_src;
      addr_good.adr_par = ~^addr_src.adr[30:5];
      addr_good.cmd_par = ~^{addr_src.adr[39:31], addr_src.adr[4:3], addr_src.bank, addr_src.cmd};
   end
   always_comb
   begin
      bad = addr_good;
      bad.adr_par = addr_good.adr_par ^ par_flip;
      bad.adr[39] = addr_good.adr[39] ^ adr_flip;
      addr_sensed = bus_cyc ? bad : {$bits(bel_pkg::bel_addr_bus_t){idle_tog}};
   end
endmodule

// *** test/bel_logger_test.sv ***
// self-checking bench: loggers of all three node kinds on shared stimulus
`timescale 1ns/100ps
`include "bel_params.svh"
module bel_logger_test;
   localparam logic [7:0] ST = `BEL_OFS_STATUS;
   localparam logic [7:0] CF = `BEL_OFS_CONFIG;
   localparam logic [23:0] NP = 24'h0FFFFF;
   localparam logic [8:0] EVT [9] = '{9'h100, 9'h080, 9'h060, 9'h070, 9'h040, 9'h008, 9'h004,
      9'h002, 9'h001};
   localparam int FLG [9] = '{9, 8, 4, 4, 4, 7, 2, 2, 3};
   logic ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, io_irq_enable = 1'b0;
   logic addr_check_en = 1'b0, addr_drive_en = 1'b0, xmitter = 1'b0, io_commander = 1'b0;
   logic ack_drive = 1'b0, ack_pull = 1'b0, bus_cyc = 1'b0, par_flip = 1'b0, adr_flip = 1'b0;
   logic ack_sensed;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic [9:0] req_drive = 10'h0, req_pull = 10'h0, req_sensed;
   bel_pkg::bel_ecc_evt_t ecc_evt = '0;
   bel_pkg::bel_bus_evt_t bus_evt = '0;
   bel_pkg::bel_addr_bus_t addr_src = '0, addr_good, addr_sensed;
   wire [31:0] rdata [3];
   wire [2:0] fault, derr, bavl, irq, noop, nxm, fill;
   int num_errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   // 125 MHz clock
   always #4 ref_clk = ~ref_clk;
   // one logger per node kind
   for (genvar g = 0; g < 3; g++)
   begin : gen_node
      bel_logger #(.NODE_KIND(bel_pkg::bel_node_kind_t'(g))) i_bel_logger (
         .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
         .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata[g]), .io_irq_enable(io_irq_enable),
         .ecc_evt(ecc_evt), .bus_evt(bus_evt), .addr_check_en(addr_check_en),
         .addr_drive_en(addr_drive_en), .addr_driven(addr_good), .addr_sensed(addr_sensed),
         .arb_request_drive(req_drive), .arb_request_sensed(req_sensed), .ack_drive(ack_drive),
         .ack_sensed(ack_sensed), .node_was_addr_xmitter(xmitter), .io_commander(io_commander),
         .system_fault_line(fault[g]), .data_error_line(derr[g]), .bank_available_assert(bavl[g]),
         .irq17_post(irq[g]), .cmd_noop(noop[g]), .csr_nxm_wr(nxm[g]), .fill_error(fill[g]));
   end
   bel_bus_model i_bel_bus_model (.ref_clk(ref_clk), .req_drive(req_drive), .req_pull(req_pull),
      .req_sensed(req_sensed), .ack_drive(ack_drive), .ack_pull(ack_pull), .ack_sensed(ack_sensed),
      .addr_src(addr_src), .bus_cyc(bus_cyc), .par_flip(par_flip), .adr_flip(adr_flip),
      .addr_good(addr_good), .addr_sensed(addr_sensed));
   // compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // verdict and end of run
   task automatic test_done();
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // flags each node kind implements
   function automatic logic [23:0] impl(input int g);
      return (g == 1) ? `BEL_IMPL_MEM : ((g == 0) ? `BEL_IMPL_CPU : `BEL_IMPL_IO);
   endfunction
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   // read data stand in the cycle after the strobe
   task automatic reg_read(input logic [7:0] a);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
   endtask
   // status of every kind; x holds io-only extras, m the bits looked at
   task automatic chk_st(input logic [23:0] f, input logic [23:0] x, input logic [23:0] m);
      reg_read(ST);
      for (int g = 0; g < 3; g++)
         check(rdata[g] & {8'hFF, m}, {8'h00, (f | (g == 2 ? x : 24'h0)) & impl(g) & m});
   endtask
   task automatic chk_cfg(input logic [31:0] d);
      reg_read(CF);
      for (int g = 0; g < 3; g++)
         check(rdata[g], d & (g == 1 ? 32'h80000007 : 32'h80000003));
   endtask
   task automatic chk_fault(input logic [23:0] f);
      for (int g = 0; g < 3; g++)
         check(fault[g], |(f & impl(g) & `BEL_FATAL_MASK));
   endtask
   // let the staged event be taken, release it, look in the cycle after
   task automatic fire();
      @(posedge ref_clk);
      ecc_evt <= '0;
      bus_evt <= '0;
      addr_check_en <= 1'b0;
      addr_drive_en <= 1'b0;
      ack_drive <= 1'b0;
      req_drive <= 10'h0;
      bus_cyc <= 1'b0;
      @(negedge ref_clk);
   endtask
   // hang guard
   always @(posedge ref_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         num_errors++;
         test_done();
      end
   end
   initial
   begin
      logic [31:0] d;
      logic [63:0] r;
      logic [3:0] p;
      logic [3:0] u;
      bel_pkg::bel_addr_bus_t s;
      void'($urandom(99));
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      chk_st(24'h0, 24'h0, 24'hFFFFFF);
      chk_cfg(32'h0);
      d = $urandom() & 32'h7FFFFFFF;
      reg_write(CF, d);
      chk_cfg(d);
      reg_write(CF, 32'h0);
      // unmapped places read zero and ignore writes
      repeat (3)
      begin
         d = {24'h0, 8'h44 ^ 8'($urandom_range(3, 1) << 6)};
         reg_write(d[7:0], 32'hFFFFFFFF);
         reg_read(d[7:0]);
         for (int g = 0; g < 3; g++) check(rdata[g], 32'h0);
      end
      chk_st(24'h0, 24'h0, 24'hFFFFFF);
      // correctable read, write, repeat write, then uncorrectable
      p = 4'($urandom_range(15, 1));
      u = ~p;
      @(posedge ref_clk);
      io_irq_enable <= 1'b1;
      ecc_evt.corr_read_ecc_flag <= p;
      fire();
      check(derr, 3'b111);
      @(negedge ref_clk);
      check(irq, 3'b100);
      chk_st({p, 20'h40000}, 24'h0, 24'hFFFFFF);
      repeat (2)
      begin
         @(posedge ref_clk);
         ecc_evt.corr_write_ecc_flag <= 4'($urandom_range(15, 1));
         fire();
         check(derr, 3'b111);
      end
      chk_st({p, 20'hE0000}, 24'h0, 24'hFFFFFF);
      @(posedge ref_clk);
      ecc_evt.uecc <= (u == 4'h0) ? 4'h1 : u;
      fire();
      check({derr, irq}, 6'b111100);
      chk_st({(u == 4'h0) ? 4'h1 : u, 20'hF0000}, 24'h0, 24'hFFFFFF);
      reg_write(ST, 32'hFFFFFFFF);
      chk_st(24'h0, 24'h0, NP);
      // disables hold the data error line and the lock timeout back
      reg_write(CF, 32'h7);
      @(posedge ref_clk);
      ecc_evt.corr_read_ecc_flag <= p;
      bus_evt.lock_timeout <= 1'b1;
      fire();
      check(derr, 3'b000);
      check(bavl, 3'b000);
      @(posedge ref_clk);
      ecc_evt.corr_write_ecc_flag <= p;
      fire();
      check(derr, 3'b000);
      chk_st(24'h060000, 24'h0, NP);
      reg_write(ST, 32'hFFFFFFFF);
      reg_write(CF, 32'h0);
      // single protocol events, one after another
      for (int i = 0; i < 9; i++)
      begin
         @(posedge ref_clk);
         bus_evt <= bel_pkg::bel_bus_evt_t'(EVT[i]);
         fire();
         chk_fault(24'h1 << FLG[i]);
         check({nxm, fill}, {2'b00, i == 2, 2'b00, i == 4});
         check(noop & 3'b101, {i == 5, 1'b0, i == 5});
         check(bavl, {1'b0, i == 8, 1'b0});
         check(irq, {i >= 2 && i <= 5, 2'b00});
         chk_st(24'h1 << FLG[i], (FLG[i] == 2) ? 24'h400 : 24'h0, NP);
         reg_write(ST, 32'hFFFFFFFF);
      end
      // ack line reads low while driven
      @(posedge ref_clk);
      ack_drive <= 1'b1;
      ack_pull <= 1'b1;
      io_commander <= 1'b1;
      fire();
      chk_fault(24'h40);
      chk_st(24'h40, 24'h10, NP);
      reg_write(ST, 32'hFFFFFFFF);
      // one driven request line reads low
      d = $urandom_range(1023, 1);
      @(posedge ref_clk);
      req_drive <= d[9:0];
      req_pull <= d[9:0] & (~d[9:0] + 10'h1);
      fire();
      chk_fault(24'h20);
      chk_st(24'h20, 24'h0, NP);
      reg_write(ST, 32'hFFFFFFFF);
      // clean address cycle, then one with bad parity
      for (int k = 0; k < 2; k++)
      begin
         r = {$urandom(), $urandom()};
         s = r[45:0];
         s.adr[4:3] = 2'b00;
         @(posedge ref_clk);
         addr_src <= s;
         bus_cyc <= 1'b1;
         addr_check_en <= 1'b1;
         par_flip <= (k == 1);
         fire();
         chk_fault((k == 1) ? 24'h2 : 24'h0);
         chk_st((k == 1) ? 24'h402 : 24'h0, 24'h0, NP);
      end
      reg_write(ST, 32'hFFFFFFFF);
      // sensed address differs from the driven copy
      @(posedge ref_clk);
      bus_cyc <= 1'b1;
      addr_drive_en <= 1'b1;
      adr_flip <= 1'b1;
      par_flip <= 1'b0;
      fire();
      chk_fault(24'h1);
      chk_st(24'h401, 24'h0, NP);
      reg_write(ST, 32'hFFFFFFFF);
      @(posedge ref_clk);
      xmitter <= 1'b1;
      bus_evt.mem_no_ack <= 1'b1;
      fire();
      chk_st(24'h500, 24'h0, NP);
      reg_write(ST, 32'hFFFFFFFF);
      // first flag freezes the register, lines still pulse
      reg_write(CF, 32'h80000000);
      io_commander <= 1'b0;
      @(posedge ref_clk);
      ack_drive <= 1'b1;
      fire();
      @(posedge ref_clk);
      req_drive <= d[9:0];
      fire();
      chk_fault(24'h20);
      reg_write(ST, 32'h0);
      chk_st(24'h40, 24'h0, NP);
      reg_write(ST, 32'h40);
      @(posedge ref_clk);
      req_drive <= d[9:0];
      fire();
      chk_st(24'h20, 24'h0, NP);
      // mid-run reset clears flags and configuration
      @(posedge ref_clk);
      rst <= 1'b1;
      @(posedge ref_clk);
      rst <= 1'b0;
      chk_st(24'h0, 24'h0, 24'hFFFFFF);
      chk_cfg(32'h0);
      test_done();
   end
endmodule
